// ### design/obl_pkg.sv
// Purpose: shared constants for the offset and bit sync tracking loops
// Assumes: 8-bit register port, signed error samples from the demodulator
// Notes: gains are carried in half-K units so that K/2 is a whole number
package obl_pkg;
  // register map
  localparam logic [7:0] FOC_CFG_ADDR = 8'h19;
  localparam logic [7:0] BS_CFG_ADDR = 8'h1a;
  localparam logic [7:0] FOC_CFG_RST = 8'h36;
  localparam logic [7:0] BS_CFG_RST = 8'h6c;
  localparam logic [7:0] FOC_CFG_WMASK = 8'h3f;
  // frequency offset config fields
  localparam int FOC_GATE_BIT = 5;
  localparam int FOC_PRE_LSB = 3;
  localparam int FOC_POST_BIT = 2;
  localparam int FOC_LIM_LSB = 0;
  // bit sync config fields
  localparam int BS_KI_PRE_LSB = 6;
  localparam int BS_KP_PRE_LSB = 4;
  localparam int BS_KI_POST_BIT = 3;
  localparam int BS_KP_POST_BIT = 2;
  localparam int BS_LIM_LSB = 0;
  // datapath widths
  localparam int ERR_W = 12;
  localparam int GAIN_W = 4;
  localparam int PROD_W = ERR_W + GAIN_W + 1;
  localparam int ACC_W = 16;
  localparam int STEP_W = 18;
  // one error lsb times gain K moves the estimate by one lsb
  localparam int GAIN_SHIFT = 1;
  localparam logic [GAIN_W-1:0] GAIN_HALF_K = 4'h1;
  localparam logic [GAIN_W-1:0] GAIN_ONE_K = 4'h2;
  // channel bandwidth is 2^14 estimate lsbs
  localparam logic [ACC_W-1:0] FOC_LIM_0 = 16'h0000;
  localparam logic [ACC_W-1:0] FOC_LIM_1 = 16'h0800;
  localparam logic [ACC_W-1:0] FOC_LIM_2 = 16'h1000;
  localparam logic [ACC_W-1:0] FOC_LIM_3 = 16'h2000;
  // nominal data rate is 2^16 step lsbs
  localparam logic [ACC_W-1:0] BS_LIM_0 = 16'h0000;
  localparam logic [ACC_W-1:0] BS_LIM_1 = 16'h0800;
  localparam logic [ACC_W-1:0] BS_LIM_2 = 16'h1000;
  localparam logic [ACC_W-1:0] BS_LIM_3 = 16'h2000;
  localparam logic [STEP_W-1:0] NOM_STEP = 18'h10000;

  typedef enum logic {OBL_PRESYNC, OBL_POSTSYNC} obl_sync_e;
endpackage

// ### design/obl_acc_if.sv
// Purpose: carries one tracking accumulator's controls and result
// Assumes: one clock domain, driven from the loop top
// Notes: ctrl side drives, loop side accumulates
`timescale 1ns/1ps
`default_nettype none
interface obl_acc_if;
  import obl_pkg::*;
  logic ce;
  logic clear;
  logic en;
  logic signed [ERR_W-1:0] err;
  logic [GAIN_W-1:0] gain_half;
  logic [ACC_W-1:0] limit;
  logic signed [ACC_W-1:0] acc;
  modport loop (input ce, input clear, input en, input err, input gain_half, input limit,
    output acc);
  modport ctrl (output ce, output clear, output en, output err, output gain_half,
    output limit, input acc);
endinterface
`default_nettype wire

// ### design/obl_track_acc.sv
// Purpose: gain, accumulate and saturate one loop estimate
// Assumes: limit is a magnitude, zero disables the estimate entirely
// Notes: saturation is symmetric about zero
`timescale 1ns/1ps
`default_nettype none
module obl_track_acc
  import obl_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // loop controls and result
  obl_acc_if.loop a
);
  typedef struct packed {
    logic signed [ACC_W-1:0] acc;
  } obl_acc_s;

  obl_acc_s st_r;
  obl_acc_s st_nxt;
  logic signed [PROD_W-1:0] prod;
  logic signed [PROD_W-1:0] delta;
  logic signed [PROD_W-1:0] sum;
  logic signed [PROD_W-1:0] lim;

  always_comb
  begin
    st_nxt = st_r;
    prod = PROD_W'(a.err * $signed({1'b0, a.gain_half}));
    delta = prod >>> GAIN_SHIFT;
    sum = PROD_W'($signed({{(PROD_W-ACC_W){st_r.acc[ACC_W-1]}}, st_r.acc}) + delta);
    lim = $signed({{(PROD_W-ACC_W){1'b0}}, a.limit});
    if (a.clear)
      st_nxt.acc = '0;
    else if (a.en)
    begin
      // clip in the wide domain so a large step cannot wrap past the limit
      if (sum > lim)
        st_nxt.acc = ACC_W'(lim);
      else if (sum < -lim)
        st_nxt.acc = ACC_W'(-lim);
      else
        st_nxt.acc = ACC_W'(sum);
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
      st_r <= '0;
    else if (a.ce)
      st_r <= st_nxt;
  end

  assign a.acc = st_r.acc;
endmodule
`default_nettype wire

// ### design/obl_loops.sv
// Purpose: frequency offset and clock recovery tracking loops with their config registers
// Assumes: demodulator strobes and error samples are synchronous to ref_clk
// Notes: gains switch to post-sync values in the same cycle as sync_detect
//
// Overview of operation
// - gate bit freezes both loops until carrier sense
// - pre-sync frequency gain is K to 4K
// - post-sync frequency gain is same or K/2
// - frequency estimate saturates at 0, BW/8, BW/4, BW/2
// - pre-sync integral gain is K_I to 4K_I
// - integral path tracks data rate mismatch
// - pre-sync proportional gain is K_P to 4K_P
// - post-sync integral gain is same or K_I/2
// - post-sync proportional gain is same or K_P
// - rate correction saturates at 0 to 12.5 percent
//
// Local design decision: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module obl_loops
  import obl_pkg::*;
(
  // clock, reset, enable
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // demodulator events
  input wire logic rx_start,
  input wire logic carrier_sense,
  input wire logic sync_detect,
  // error samples
  input wire logic freq_err_valid,
  input wire logic signed [ERR_W-1:0] freq_err,
  input wire logic timing_err_valid,
  input wire logic signed [ERR_W-1:0] timing_err,
  // loop results
  output logic signed [ACC_W-1:0] freq_offset_est,
  output logic signed [ACC_W-1:0] rate_offset,
  output logic [STEP_W-1:0] phase_step,
  output logic loops_frozen,
  output logic sync_found
);
  typedef struct packed {
    logic [7:0] foc_cfg;
    logic [7:0] bs_cfg;
    obl_sync_e sync;
    logic cs_seen;
    logic frozen;
    logic [7:0] rdata;
    logic [STEP_W-1:0] step;
  } obl_top_s;

  obl_top_s st_r;
  obl_top_s st_nxt;

  obl_acc_if freq_if ();
  obl_acc_if rate_if ();

  logic loops_carrier_gate;
  logic [1:0] freq_gain_presync;
  logic freq_gain_postsync_sel;
  logic [1:0] freq_offset_saturation;
  logic [1:0] clkrec_integral_presync;
  logic [1:0] clkrec_prop_presync;
  logic clkrec_integral_postsync_sel;
  logic clkrec_prop_postsync_sel;
  logic [1:0] rate_offset_saturation;
  logic post_gain;
  logic freeze;
  logic [GAIN_W-1:0] freq_gain;
  logic [GAIN_W-1:0] ki_gain;
  logic [GAIN_W-1:0] kp_gain;
  logic [ACC_W-1:0] freq_lim;
  logic [ACC_W-1:0] rate_lim;
  logic signed [PROD_W-1:0] prop_prod;
  logic signed [PROD_W-1:0] prop_term;
  logic signed [STEP_W-1:0] step_sum;

  // settings 0..3 map to 1..4 times the base gain, in half units
  function automatic logic [GAIN_W-1:0] pre_gain(input logic [1:0] sel);
    pre_gain = GAIN_W'(({2'b00, sel} + 4'h1) << 1);
  endfunction

  assign loops_carrier_gate = st_r.foc_cfg[FOC_GATE_BIT];
  assign freq_gain_presync = st_r.foc_cfg[FOC_PRE_LSB +: 2];
  assign freq_gain_postsync_sel = st_r.foc_cfg[FOC_POST_BIT];
  assign freq_offset_saturation = st_r.foc_cfg[FOC_LIM_LSB +: 2];
  assign clkrec_integral_presync = st_r.bs_cfg[BS_KI_PRE_LSB +: 2];
  assign clkrec_prop_presync = st_r.bs_cfg[BS_KP_PRE_LSB +: 2];
  assign clkrec_integral_postsync_sel = st_r.bs_cfg[BS_KI_POST_BIT];
  assign clkrec_prop_postsync_sel = st_r.bs_cfg[BS_KP_POST_BIT];
  assign rate_offset_saturation = st_r.bs_cfg[BS_LIM_LSB +: 2];

  always_comb
  begin
    post_gain = (st_r.sync == OBL_POSTSYNC) || sync_detect;
    freeze = loops_carrier_gate && !st_r.cs_seen && !carrier_sense;

    freq_gain = pre_gain(freq_gain_presync);
    if (post_gain && freq_gain_postsync_sel)
      freq_gain = GAIN_HALF_K;

    ki_gain = pre_gain(clkrec_integral_presync);
    if (post_gain && clkrec_integral_postsync_sel)
      ki_gain = GAIN_HALF_K;

    kp_gain = pre_gain(clkrec_prop_presync);
    if (post_gain && clkrec_prop_postsync_sel)
      kp_gain = GAIN_ONE_K;

    case (freq_offset_saturation)
      2'h0: freq_lim = FOC_LIM_0;
      2'h1: freq_lim = FOC_LIM_1;
      2'h2: freq_lim = FOC_LIM_2;
      default: freq_lim = FOC_LIM_3;
    endcase

    case (rate_offset_saturation)
      2'h0: rate_lim = BS_LIM_0;
      2'h1: rate_lim = BS_LIM_1;
      2'h2: rate_lim = BS_LIM_2;
      default: rate_lim = BS_LIM_3;
    endcase
  end

  // frequency offset loop
  assign freq_if.ce = clk_en;
  assign freq_if.clear = rx_start;
  assign freq_if.en = freq_err_valid && !freeze;
  assign freq_if.err = freq_err;
  assign freq_if.gain_half = freq_gain;
  assign freq_if.limit = freq_lim;

  assign rate_if.ce = clk_en;
  assign rate_if.clear = rx_start;
  assign rate_if.en = timing_err_valid && !freeze;
  assign rate_if.err = timing_err;
  assign rate_if.gain_half = ki_gain;
  assign rate_if.limit = rate_lim;

  obl_track_acc u_freq_acc
  (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .a(freq_if.loop)
  );

  obl_track_acc u_rate_acc
  (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .a(rate_if.loop)
  );

  always_comb
  begin
    st_nxt = st_r;
    prop_prod = PROD_W'(timing_err * $signed({1'b0, kp_gain}));
    prop_term = prop_prod >>> GAIN_SHIFT;
    step_sum = STEP_W'($signed(NOM_STEP) + STEP_W'(rate_if.acc) + STEP_W'(prop_term));

    // register writes
    if (reg_wr)
    begin
      if (reg_addr == FOC_CFG_ADDR)
        st_nxt.foc_cfg = reg_wdata & FOC_CFG_WMASK;
      else if (reg_addr == BS_CFG_ADDR)
        st_nxt.bs_cfg = reg_wdata;
    end

    // read data stands for the cycle after the strobe only
    st_nxt.rdata = 8'h00;
    if (reg_rd)
    begin
      if (reg_addr == FOC_CFG_ADDR)
        st_nxt.rdata = st_r.foc_cfg;
      else if (reg_addr == BS_CFG_ADDR)
        st_nxt.rdata = st_r.bs_cfg;
    end

    if (rx_start)
    begin
      st_nxt.sync = OBL_PRESYNC;
      st_nxt.cs_seen = 1'b0;
    end
    else
    begin
      case (st_r.sync)
        OBL_PRESYNC:
          if (sync_detect)
            st_nxt.sync = OBL_POSTSYNC;
        default:
          st_nxt.sync = OBL_POSTSYNC;
      endcase
    end
    // carrier seen sticks; it wins over a clear in the same cycle
    if (carrier_sense)
      st_nxt.cs_seen = 1'b1;

    st_nxt.frozen = freeze;
    // proportional kick is applied only on a fresh timing sample
    if (rx_start)
      st_nxt.step = NOM_STEP;
    else if (timing_err_valid && !freeze)
      st_nxt.step = step_sum;
    else
      st_nxt.step = STEP_W'($signed(NOM_STEP) + STEP_W'(rate_if.acc));
  end

  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      st_r.foc_cfg <= FOC_CFG_RST;
      st_r.bs_cfg <= BS_CFG_RST;
      st_r.sync <= OBL_PRESYNC;
      st_r.cs_seen <= 1'b0;
      st_r.frozen <= 1'b0;
      st_r.rdata <= 8'h00;
      st_r.step <= NOM_STEP;
    end
    else if (clk_en)
      st_r <= st_nxt;
  end

  assign reg_rdata = st_r.rdata;
  assign freq_offset_est = freq_if.acc;
  assign rate_offset = rate_if.acc;
  assign phase_step = st_r.step;
  assign loops_frozen = st_r.frozen;
  assign sync_found = (st_r.sync == OBL_POSTSYNC);
endmodule
`default_nettype wire

// ### sim/obl_loops_properties.sv
// Purpose: port level checker for the tracking loops
// Assumes: clk_en held high by the bench
// Notes: config fields are not visible here, so limits use the widest setting
`timescale 1ns/1ps
`default_nettype none
module obl_loops_chk
  import obl_pkg::*;
(
  // watched ports
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic rx_start,
  input wire logic carrier_sense,
  input wire logic sync_detect,
  input wire logic timing_err_valid,
  input wire logic signed [ACC_W-1:0] freq_offset_est,
  input wire logic signed [ACC_W-1:0] rate_offset,
  input wire logic [STEP_W-1:0] phase_step,
  input wire logic loops_frozen,
  input wire logic sync_found
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  property p_rd_idle; !$past(reg_rd) |-> reg_rdata == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data not idle");
  property p_cs_rel; carrier_sense |=> !loops_frozen; endproperty
  a_cs_rel: assert property (p_cs_rel)
    else $error("loops still frozen after carrier");
  // frozen flag lags the freeze by one cycle, as does the estimate
  property p_frz; loops_frozen && !$past(rx_start) |-> $stable(freq_offset_est)
    && $stable(rate_offset); endproperty
  a_frz: assert property (p_frz)
    else $error("estimate moved while frozen");
  property p_fcap; freq_offset_est <= 16'sh2000 && freq_offset_est >= -16'sh2000; endproperty
  a_fcap: assert property (p_fcap)
    else $error("frequency estimate beyond widest limit");
  property p_rcap; rate_offset <= 16'sh2000 && rate_offset >= -16'sh2000; endproperty
  a_rcap: assert property (p_rcap)
    else $error("rate correction beyond widest limit");
  // without a timing sample the step is the nominal step plus the old correction
  property p_step; !$past(timing_err_valid) && !$past(rx_start) |-> phase_step == NOM_STEP
    + 18'($past(rate_offset)); endproperty
  a_step: assert property (p_step)
    else $error("phase step not nominal plus rate");
  property p_sync; sync_detect && !rx_start |=> sync_found; endproperty
  a_sync: assert property (p_sync)
    else $error("sync not entered");
  property p_hold; sync_found && !rx_start |=> sync_found; endproperty
  a_hold: assert property (p_hold)
    else $error("post sync state lost");
  property p_rx; rx_start |=> !sync_found && freq_offset_est == '0
    && rate_offset == '0 && phase_step == NOM_STEP; endproperty
  a_rx: assert property (p_rx)
    else $error("new reception did not restart loops");
  c_sync: cover property (sync_detect ##1 sync_found);
  c_rel: cover property (loops_frozen ##1 !loops_frozen);
  c_sat: cover property (freq_offset_est == 16'sh2000);
endmodule
bind obl_loops obl_loops_chk chk (.ref_clk, .reset_n, .reg_rd, .reg_rdata, .rx_start,
  .carrier_sense, .sync_detect, .timing_err_valid, .freq_offset_est, .rate_offset,
  .phase_step, .loops_frozen, .sync_found);
`default_nettype wire

// ### sim/test_obl_loops.sv
// Purpose: directed bench for the tracking loops
// Assumes: clk_en held high; both error inputs share one sample
// Notes: expectations use half-K gain units with one right shift
`timescale 1ns/1ps
`default_nettype none
module test_obl_loops
  import obl_pkg::*;
;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic rx_start = 1'b0;
  logic carrier_sense = 1'b0;
  logic sync_detect = 1'b0;
  logic err_vld = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic signed [ERR_W-1:0] err = 12'sh000;
  logic [7:0] reg_rdata;
  logic signed [ACC_W-1:0] fest;
  logic signed [ACC_W-1:0] rate;
  logic [STEP_W-1:0] step;
  logic frz;
  logic synf;
  int error_cnt = 0;
  int num_checks = 0;
  int cyc = 0;
  int lim[4] = '{0, 2048, 4096, 8192};
  int g;
  obl_loops dut (
    .ref_clk(ref_clk), .reset_n(reset_n), .clk_en(1'b1),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .rx_start(rx_start), .carrier_sense(carrier_sense),
    .sync_detect(sync_detect), .freq_err_valid(err_vld), .freq_err(err),
    .timing_err_valid(err_vld), .timing_err(err), .freq_offset_est(fest),
    .rate_offset(rate), .phase_step(step), .loops_frozen(frz), .sync_found(synf)
  );
  always #10 ref_clk = ~ref_clk;
  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // run takes well under a thousand cycles
  always @(posedge ref_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      error_cnt++;
      tally_and_finish();
    end
  end
  task automatic chk(input logic [17:0] got, input logic [17:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic ck2(input int f, input int r);
    chk(18'(fest), 18'(f));
    chk(18'(rate), 18'(r));
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 chk(18'(reg_rdata), 18'(exp));
  endtask
  // one cycle of events; outputs are settled when it returns
  task automatic drive(input logic rx, input logic sy, input logic v, input int e);
    @(posedge ref_clk);
    rx_start <= rx;
    sync_detect <= sy;
    err_vld <= v;
    err <= 12'(e);
    @(posedge ref_clk);
    {rx_start, sync_detect, err_vld} <= 3'h0;
    #1;
  endtask
  initial
  begin
    repeat (16) @(posedge ref_clk);
    reset_n <= 1'b1;
    rd(8'h19, 8'h36);
    rd(8'h1a, 8'h6c);
    rd(8'h1b, 8'h00);
    $display("test reset_values done");
    drive(1'b1, 1'b0, 1'b0, 0);
    drive(1'b0, 1'b0, 1'b1, 100);
    ck2(0, 0);
    chk(18'(frz), 18'h1);
    @(posedge ref_clk);
    carrier_sense <= 1'b1;
    @(posedge ref_clk);
    carrier_sense <= 1'b0;
    drive(1'b0, 1'b0, 1'b1, 100);
    ck2(300, 0);
    chk(18'(frz), 18'h0);
    chk(step, 18'h1012c);
    drive(1'b1, 1'b0, 1'b0, 0);
    ck2(0, 0);
    drive(1'b0, 1'b0, 1'b1, 100);
    ck2(0, 0);
    $display("test freeze done");
    wr(8'h19, 8'hff);
    rd(8'h19, 8'h3f);
    wr(8'h1b, 8'h55);
    rd(8'h1b, 8'h00);
    wr(8'h1a, 8'ha5);
    rd(8'h1a, 8'ha5);
    $display("test registers done");
    for (int s = 0; s < 4; s++)
    begin
      for (int p = 0; p < 2; p++)
      begin
        g = 100 * (s + 1);
        wr(8'h19, 8'((s << 3) | (p << 2) | 3));
        wr(8'h1a, 8'((s << 6) | (s << 4) | (p << 3) | (p << 2) | 3));
        drive(1'b1, 1'b0, 1'b0, 0);
        chk(18'(synf), 18'h0);
        drive(1'b0, 1'b0, 1'b1, 100);
        ck2(g, g);
        chk(step, 18'(65536 + g));
        drive(1'b0, 1'b1, 1'b1, 100);
        ck2(g + (p ? 50 : g), g + (p ? 50 : g));
        chk(18'(synf), 18'h1);
        chk(step, 18'(65536 + g + (p ? 100 : g)));
      end
    end
    $display("test gains done");
    for (int l = 0; l < 4; l++)
    begin
      wr(8'h19, 8'(8'h18 | l));
      wr(8'h1a, 8'(8'hf0 | l));
      drive(1'b1, 1'b0, 1'b0, 0);
      repeat (2) drive(1'b0, 1'b0, 1'b1, 2047);
      ck2(lim[l], lim[l]);
      repeat (3) drive(1'b0, 1'b0, 1'b1, -2048);
      ck2(-lim[l], -lim[l]);
    end
    $display("test saturation done");
    // keyed-carrier setup: software parks the frequency limit at zero
    wr(8'h19, 8'h1c);
    drive(1'b1, 1'b0, 1'b0, 0);
    drive(1'b0, 1'b0, 1'b1, 100);
    ck2(0, 400);
    $display("test ook_limit done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
